// *** hspc_consts.vh ***
// Purpose: constants for the halt/standby power controller
// Assumes: one system clock, synchronous active-high reset
// Notes: definitions only
`ifndef HSPC_CONSTS_VH
`define HSPC_CONSTS_VH
`define HSPC_RESET_VECTOR 12'h000
`define HSPC_ADDR_W 12
`define HSPC_CNT_W 8
`define HSPC_WAKE_INSNS 2'h2
`endif

// *** hspc_sync2.v ***
// Purpose: two-flop level synchroniser
// Assumes: d is a level from outside the clock domain
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module hspc_sync2 #(
    parameter RST_VAL = 1'b1
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // data
    input wire d,
    output reg q
);
    reg meta_r;

    always @(posedge clk_sys) begin
        if (srst) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// *** hspc_event_counter.v ***
// Purpose: 8-bit event counter with halt-mode first-pulse capture
// Assumes: ev_rise is a one-cycle pulse per counter-input rising edge
// Notes: while halted only the first pulse is counted
`timescale 1ns/1ns
`include "hspc_consts.vh"
module hspc_event_counter (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // control
    input wire cnt_en,
    input wire halted,
    input wire ev_rise,
    // count
    output reg [`HSPC_CNT_W-1:0] count_r
);
    reg halt_taken_r;

    always @(posedge clk_sys) begin
        if (srst) begin
            count_r <= {`HSPC_CNT_W{1'b0}};
            halt_taken_r <= 1'b0;
        end else begin
            if (!halted)
                halt_taken_r <= 1'b0;
            if (cnt_en && ev_rise) begin
                if (!halted) begin
                    count_r <= count_r + 8'h01;
                end else if (!halt_taken_r) begin
                    count_r <= count_r + 8'h01; // [R6]
                    halt_taken_r <= 1'b1;
                end
            end
        end
    end
endmodule

// *** hspc_power_ctrl.v ***
// Purpose: halt and standby low-power mode controller
// Assumes: core gives halt_exec pulse and its own strobes; pins may be asynchronous
// Notes: outputs registered; standby gates everything but data memory
//
// Summary of operation
// R1 - halt instruction enters halt, fetch and execution stop until wake
// R2 - in halt only oscillator runs; timer frozen, registers retained
// R3 - halted data bus keeps output data or floats; ports keep latched data
// R4 - halted: address latch strobe low; fetch, read, write, expander strobes high
// R5 - halted test-zero pin keeps clock output if it was enabled
// R6 - halted event counter takes only first pulse, then counts on normally
// R7 - reset low while halted releases halt, full reset, starts at address 0
// R8 - interrupt low with interrupts enabled: run two instructions then interrupt
// R9 - interrupt low with interrupts disabled: resume after halt, no interrupt
// R10 - controller drives reset low before pulling standby input low
// R11 - standby stops everything including clock; only data memory kept
// R12 - leave standby: standby high while reset low, then reset high, start 0
// R13 - reset, interrupt and standby inputs pass through synchronisers
`timescale 1ns/1ns
`include "hspc_consts.vh"
module hspc_power_ctrl (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // external pins
    input wire reset_pin_n,
    input wire int_pin_n,
    input wire low_power_hold_n,
    input wire event_count_input,
    // core status and strobes
    input wire halt_exec,
    input wire insn_done,
    input wire int_enabled,
    input wire core_ale,
    input wire core_program_fetch_strobe_n,
    input wire core_rd_n,
    input wire core_wr_n,
    input wire core_prog_n,
    input wire [7:0] core_bus_out,
    input wire core_bus_oe,
    input wire [7:0] core_p1,
    input wire [7:0] core_p2,
    input wire clk_out_en,
    input wire int_clk,
    input wire cnt_en,
    input wire [`HSPC_ADDR_W-1:0] halt_next_pc,
    // core control
    output reg core_run_r,
    output reg core_reset_r,
    output reg [`HSPC_ADDR_W-1:0] start_pc_r,
    output reg start_pc_load_r,
    output reg int_take_r,
    output reg osc_run_r,
    output reg ram_retain_r,
    output reg [`HSPC_CNT_W-1:0] event_count_r,
    // pins
    output reg ale_r,
    output reg program_fetch_strobe_n_r,
    output reg rd_n_r,
    output reg wr_n_r,
    output reg prog_n_r,
    output reg [7:0] bus_o_r,
    output reg bus_oe_r,
    output reg [7:0] p1_o_r,
    output reg [7:0] p2_o_r,
    output reg test_zero_pin_o_r,
    output reg test_zero_pin_oe_r,
    output reg halted_r
);
    localparam ST_RUN = 5'b00001;
    localparam ST_HALT = 5'b00010;
    localparam ST_WAKE = 5'b00100;
    localparam ST_RSTW = 5'b01000;
    localparam ST_LOW_POWER_HOLD_N = 5'b10000;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    wire rst_s;
    wire int_s;
    wire low_power_hold_n_s;
    wire ev_s;
    reg ev_d_r;
    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg [1:0] wake_cnt_r;
    reg wake_int_r;

    hspc_sync2 #(
        .RST_VAL(1'b1)
    ) u_sync_rst ( // [R13]
        .clk_sys(clk_sys),
        .srst(srst),
        .d(reset_pin_n),
        .q(rst_s)
    );

    hspc_sync2 #(
        .RST_VAL(1'b1)
    ) u_sync_int ( // [R13]
        .clk_sys(clk_sys),
        .srst(srst),
        .d(int_pin_n),
        .q(int_s)
    );

    hspc_sync2 #(
        .RST_VAL(1'b1)
    ) u_sync_low_power_hold_n ( // [R13]
        .clk_sys(clk_sys),
        .srst(srst),
        .d(low_power_hold_n),
        .q(low_power_hold_n_s)
    );

    hspc_sync2 #(
        .RST_VAL(1'b0)
    ) u_sync_ev (
        .clk_sys(clk_sys),
        .srst(srst),
        .d(event_count_input),
        .q(ev_s)
    );

    always @(posedge clk_sys) begin
        if (srst)
            ev_d_r <= 1'b0;
        else
            ev_d_r <= ev_s;
    end

    // ----------------------------------------
    // event counter
    // ----------------------------------------
    wire [`HSPC_CNT_W-1:0] ev_count;
    wire cnt_halted;

    assign cnt_halted = (state_r == ST_HALT);

    hspc_event_counter u_evcnt (
        .clk_sys(clk_sys),
        .srst(srst | core_reset_r),
        .cnt_en(cnt_en),
        .halted(cnt_halted),
        .ev_rise(ev_s & ~ev_d_r),
        .count_r(ev_count)
    );

    // ----------------------------------------
    // mode state machine
    // ----------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (!rst_s)
                    state_nxt = ST_RSTW;
                else if (halt_exec)
                    state_nxt = ST_HALT; // [R1]
            end
            ST_HALT: begin
                if (!rst_s)
                    state_nxt = ST_RSTW; // [R7]
                else if (!int_s)
                    state_nxt = ST_WAKE;
            end
            ST_WAKE: begin
                if (!rst_s)
                    state_nxt = ST_RSTW;
                else if (!wake_int_r || (insn_done && wake_cnt_r == (`HSPC_WAKE_INSNS - 2'h1)))
                    state_nxt = ST_RUN; // [R8] [R9]
            end
            ST_RSTW: begin
                // controller pulls standby low only while reset held low
                if (!low_power_hold_n_s)
                    state_nxt = ST_LOW_POWER_HOLD_N; // [R10] [R11]
                else if (rst_s)
                    state_nxt = ST_RUN; // [R7]
            end
            ST_LOW_POWER_HOLD_N: begin
                if (low_power_hold_n_s)
                    state_nxt = ST_RSTW; // [R12]
            end
            default: state_nxt = ST_RSTW;
        endcase
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            state_r <= ST_RSTW;
            wake_cnt_r <= 2'h0;
            wake_int_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_HALT && state_nxt == ST_WAKE) begin
                wake_int_r <= int_enabled;
                wake_cnt_r <= 2'h0;
            end else if (state_r == ST_WAKE && insn_done) begin
                wake_cnt_r <= wake_cnt_r + 2'h1;
            end
        end
    end

    // ----------------------------------------
    // core control and pin outputs
    // ----------------------------------------
    wire in_halt;
    wire in_rst;
    wire in_low_power_hold_n;
    wire wake_go;

    assign in_halt = (state_nxt == ST_HALT);
    assign in_rst = (state_nxt == ST_RSTW);
    assign in_low_power_hold_n = (state_nxt == ST_LOW_POWER_HOLD_N);
    assign wake_go = (state_r == ST_WAKE) && (state_nxt == ST_RUN) && wake_int_r;

    always @(posedge clk_sys) begin
        if (srst) begin
            core_run_r <= 1'b0;
            core_reset_r <= 1'b1;
            start_pc_r <= `HSPC_RESET_VECTOR;
            start_pc_load_r <= 1'b0;
            int_take_r <= 1'b0;
            osc_run_r <= 1'b1;
            ram_retain_r <= 1'b0;
            event_count_r <= {`HSPC_CNT_W{1'b0}};
            halted_r <= 1'b0;
        end else begin
            core_run_r <= ~(in_halt | in_rst | in_low_power_hold_n); // [R1] [R2]
            core_reset_r <= in_rst | in_low_power_hold_n; // [R7]
            osc_run_r <= ~in_low_power_hold_n; // [R11]
            ram_retain_r <= in_low_power_hold_n; // [R11]
            halted_r <= in_halt;
            int_take_r <= wake_go; // [R8]
            start_pc_load_r <= (state_r == ST_RSTW && state_nxt == ST_RUN)
                || (state_r == ST_HALT && state_nxt == ST_WAKE);
            if (state_r == ST_HALT && state_nxt == ST_WAKE)
                start_pc_r <= halt_next_pc; // [R9]
            else
                start_pc_r <= `HSPC_RESET_VECTOR; // [R7] [R12]
            event_count_r <= ev_count;
        end
    end

    // ----------------------------------------
    // pin outputs
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (srst) begin
            ale_r <= 1'b0;
            program_fetch_strobe_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            prog_n_r <= 1'b1;
            bus_o_r <= 8'h00;
            bus_oe_r <= 1'b0;
            p1_o_r <= 8'hFF;
            p2_o_r <= 8'hFF;
            test_zero_pin_o_r <= 1'b0;
            test_zero_pin_oe_r <= 1'b0;
        end else begin
            if (in_halt) begin
                ale_r <= 1'b0; // [R4]
                program_fetch_strobe_n_r <= 1'b1; // [R4]
                rd_n_r <= 1'b1; // [R4]
                wr_n_r <= 1'b1; // [R4]
                prog_n_r <= 1'b1; // [R4]
                // bus and ports keep their last driven values [R3]
                test_zero_pin_o_r <= int_clk & test_zero_pin_oe_r; // [R5]
            end else if (in_rst | in_low_power_hold_n) begin
                ale_r <= 1'b0;
                program_fetch_strobe_n_r <= 1'b1;
                rd_n_r <= 1'b1;
                wr_n_r <= 1'b1;
                prog_n_r <= 1'b1;
                bus_oe_r <= 1'b0;
                p1_o_r <= 8'hFF;
                p2_o_r <= 8'hFF;
                test_zero_pin_oe_r <= 1'b0;
                test_zero_pin_o_r <= 1'b0;
            end else begin
                ale_r <= core_ale;
                program_fetch_strobe_n_r <= core_program_fetch_strobe_n;
                rd_n_r <= core_rd_n;
                wr_n_r <= core_wr_n;
                prog_n_r <= core_prog_n;
                bus_o_r <= core_bus_out;
                bus_oe_r <= core_bus_oe;
                p1_o_r <= core_p1;
                p2_o_r <= core_p2;
                test_zero_pin_oe_r <= clk_out_en;
                test_zero_pin_o_r <= int_clk & clk_out_en;
            end
        end
    end
endmodule

// *** hspc_power_ctrl_monitor.sv ***
// Purpose: port checker for the power controller
// Assumes: srst synchronous, active high
// Notes: bound to every instance
`timescale 1ns/1ns
module hspc_power_ctrl_monitor (
    // clock and reset
    input wire clk_sys, srst,
    // watched ports
    input wire reset_pin_n, int_pin_n, low_power_hold_n, halt_exec, core_run_r, core_reset_r,
    input wire start_pc_load_r, osc_run_r, ram_retain_r, ale_r, program_fetch_strobe_n_r,
    input wire rd_n_r, wr_n_r, prog_n_r, bus_oe_r, test_zero_pin_oe_r, halted_r,
    input wire [7:0] bus_o_r, p1_o_r, p2_o_r, event_count_r,
    input wire [11:0] start_pc_r, halt_next_pc
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // count changes seen while halted
    logic [1:0] chg_r;
    always @(posedge clk_sys) begin
        if (srst || !halted_r) chg_r <= 2'h0;
        else if (event_count_r != $past(event_count_r) && chg_r != 2'h3) chg_r <= chg_r + 2'h1;
    end
    property p_enter; core_run_r && halt_exec |=> halted_r && !core_run_r; endproperty
    a_enter: assert property (p_enter) else $error("halt not entered");
    property p_stop; halted_r |-> !core_run_r && !start_pc_load_r; endproperty
    a_stop: assert property (p_stop) else $error("core runs in halt");
    property p_strb;
        halted_r |-> !ale_r && program_fetch_strobe_n_r && rd_n_r && wr_n_r && prog_n_r;
    endproperty
    a_strb: assert property (p_strb) else $error("strobe level in halt");
    property p_hold;
        halted_r && $past(halted_r) |-> $stable({p1_o_r, p2_o_r, bus_oe_r, test_zero_pin_oe_r});
    endproperty
    a_hold: assert property (p_hold) else $error("pin state moved in halt");
    property p_bus; halted_r && $past(halted_r) && bus_oe_r |-> $stable(bus_o_r); endproperty
    a_bus: assert property (p_bus) else $error("bus data moved in halt");
    property p_cnt; chg_r <= 2'h1; endproperty
    a_cnt: assert property (p_cnt) else $error("count moved twice in halt");
    property p_intw;
        $fell(int_pin_n) && halted_r && reset_pin_n |->
            ##[2:6] start_pc_load_r && start_pc_r == halt_next_pc;
    endproperty
    a_intw: assert property (p_intw) else $error("no resume after int");
    property p_rst; $fell(reset_pin_n) |-> ##[1:4] core_reset_r && !halted_r; endproperty
    a_rst: assert property (p_rst) else $error("reset not taken");
    property p_rstw;
        $rose(reset_pin_n) && low_power_hold_n |->
            ##[2:6] start_pc_load_r && start_pc_r == 12'h000;
    endproperty
    a_rstw: assert property (p_rstw) else $error("no start at zero");
    property p_low_power_hold_n;
        $fell(low_power_hold_n) && !reset_pin_n |-> ##[2:5] !osc_run_r && ram_retain_r;
    endproperty
    a_low_power_hold_n: assert property (p_low_power_hold_n) else $error("standby not entered");
endmodule
bind hspc_power_ctrl hspc_power_ctrl_monitor hspc_power_ctrl_monitor_i (.*);

// *** hspc_ext_ctrl.sv ***
// Purpose: external reset, standby and event source
// Assumes: pins change 2 ns after a clock edge
// Notes: tasks called by the bench
`timescale 1ns/1ns
module hspc_ext_ctrl (
    input wire clk_sys,
    output logic reset_pin_n, int_pin_n, low_power_hold_n, event_count_input
);
    initial {reset_pin_n, int_pin_n, low_power_hold_n, event_count_input} = 4'hE;
    task automatic step(input int n); repeat (n) @(posedge clk_sys); #2; endtask
    task automatic set_reset(input logic v); reset_pin_n = v; endtask
    task automatic int_level(input logic v); int_pin_n = v; endtask
    task automatic standby_enter;
        reset_pin_n = 1'h0; step(4); // reset low first
        low_power_hold_n = 1'h0;
    endtask
    task automatic standby_exit;
        low_power_hold_n = 1'h1; step(4); // hold high under reset
        reset_pin_n = 1'h1;
    endtask
    task automatic ev_pulses(input int n);
        repeat (n) begin
            event_count_input = 1'h1; step(3);
            event_count_input = 1'h0; step(3);
        end
    endtask
endmodule

// *** halt_standby_power_control_tb.sv ***
// Purpose: self-checking bench for the power controller
// Assumes: 25 MHz clock, inputs 2 ns after rising edge
// Notes: row loop for halt/wake, hand tests after
`timescale 1ns/1ns
module halt_standby_power_control_tb;
    typedef struct packed {logic ie, t0, ce, oe; logic [11:0] pc; logic [7:0] d;} hspc_row_t;
    hspc_row_t rows [3] = '{'{1, 1, 1, 1, 12'h005, 8'hA5}, '{0, 0, 1, 0, 12'hFFE, 8'h3C},
        '{1, 0, 0, 1, 12'h800, 8'h00}};
    logic clk_sys = 0, srst = 1, halt_exec = 0, insn_done = 0, int_enabled = 0, int_clk = 0;
    logic core_ale = 0, core_program_fetch_strobe_n = 1, core_rd_n = 1, core_wr_n = 1;
    logic core_prog_n = 1, core_bus_oe = 0, clk_out_en = 0, cnt_en = 0, seen;
    logic [7:0] core_bus_out = 0, core_p1 = 0, core_p2 = 0, event_count_r, bus_o_r, p1_o_r, p2_o_r;
    logic [11:0] halt_next_pc = 0, start_pc_r;
    logic reset_pin_n, int_pin_n, low_power_hold_n, event_count_input, core_run_r, core_reset_r;
    logic start_pc_load_r, int_take_r, osc_run_r, ram_retain_r, ale_r, program_fetch_strobe_n_r;
    logic rd_n_r, wr_n_r, prog_n_r, bus_oe_r, test_zero_pin_o_r, test_zero_pin_oe_r, halted_r;
    logic [4:0] stb;
    integer fail_count = 0, compares = 0, cyc = 0, i, exp_cnt = 0;
    hspc_power_ctrl hspc_power_ctrl_i (.*);
    hspc_ext_ctrl hspc_ext_ctrl_i (.*);
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        int_clk <= ~int_clk;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count = fail_count + 1;
            give_verdict;
        end
    end
    task automatic give_verdict;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic step(input int n); repeat (n) @(posedge clk_sys); #2; endtask
    task automatic chk(input logic [15:0] got, exp, input string m);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic wait_load(input logic [11:0] pc);
        for (i = 0; i < 12 && start_pc_load_r !== 1'b1; i++) step(1);
        chk(start_pc_load_r, 1, "load");
        chk(start_pc_r, pc, "start pc");
    endtask
    task automatic halt_it;
        halt_exec = 1; step(1); halt_exec = 0;
        chk(halted_r, 1, "halt");
    endtask
    task automatic insn(output logic s);
        insn_done = 1; step(1); insn_done = 0; s = 0;
        repeat (3) begin s = s | int_take_r; step(1); end
    endtask
    initial begin
        step(3);
        chk({core_reset_r, core_run_r, ale_r, bus_oe_r, p1_o_r}, 16'h08FF, "reset state");
        srst = 0; wait_load(0);
        foreach (rows[k]) begin
            int_enabled = rows[k].ie; clk_out_en = rows[k].t0; cnt_en = rows[k].ce;
            core_bus_oe = rows[k].oe; halt_next_pc = rows[k].pc; core_bus_out = rows[k].d;
            core_p1 = rows[k].d; core_p2 = ~rows[k].d; step(2); halt_it;
            stb = {rows[k].ie, rows[k].t0, rows[k].ce, rows[k].oe, ~rows[k].ie};
            core_ale = stb[4]; core_program_fetch_strobe_n = stb[3]; core_rd_n = stb[2];
            core_wr_n = stb[1]; core_prog_n = stb[0];
            core_p1 = 8'h5A; core_bus_out = 8'hC3; core_bus_oe = ~rows[k].oe; step(2);
            chk({ale_r, program_fetch_strobe_n_r, rd_n_r, wr_n_r, prog_n_r}, 5'h0F, "strb");
            chk({p1_o_r, p2_o_r}, {rows[k].d, ~rows[k].d}, "ports");
            chk({bus_oe_r, bus_o_r}, {rows[k].oe, rows[k].d}, "bus");
            chk(test_zero_pin_oe_r, rows[k].t0, "t0");
            seen = test_zero_pin_o_r; step(1); seen = seen ^ test_zero_pin_o_r;
            chk({seen, test_zero_pin_o_r | seen}, {2{rows[k].t0}}, "t0 clk");
            hspc_ext_ctrl_i.ev_pulses(3); exp_cnt += rows[k].ce;
            chk(event_count_r, exp_cnt, "count halt");
            chk(core_run_r, 0, "run");
            hspc_ext_ctrl_i.int_level(0); wait_load(rows[k].pc);
            hspc_ext_ctrl_i.int_level(1);
            chk({ale_r, program_fetch_strobe_n_r, rd_n_r, wr_n_r, prog_n_r}, stb, "run");
            hspc_ext_ctrl_i.ev_pulses(2); exp_cnt += 2 * rows[k].ce;
            chk(event_count_r, exp_cnt, "count run");
            insn(seen); chk(seen, 0, "early int");
            insn(seen); chk(seen, rows[k].ie, "int take");
        end
        halt_it; hspc_ext_ctrl_i.set_reset(0); step(4);
        chk({core_reset_r, halted_r, core_run_r}, 3'h4, "rst wake");
        hspc_ext_ctrl_i.set_reset(1); wait_load(0);
        hspc_ext_ctrl_i.standby_enter; step(4);
        chk({osc_run_r, ram_retain_r, core_reset_r}, 3'h3, "standby");
        hspc_ext_ctrl_i.standby_exit; wait_load(0);
        give_verdict;
    end
endmodule
